//--- verilog/lgoe_gate.sv
// Lock-gated output enable logic with an APB register slave.
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
`include "lgoe_defines.svh"

module lgoe_gate
    import lgoe_pkg::*;
#(
    parameter int NUM_OUT = `LGOE_NUM_OUT
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [13:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic current_source_lock_indicator_i,
    input wire logic [11:0] other_pdn_i,
    output logic [11:0] out_enable_o
);

    // -------------------------------------------------------------------------
    // APB decode
    // -------------------------------------------------------------------------
    lgoe_mask_t gate_r;
    lgoe_mask_t gate_nxt;
    lgoe_mask_t soft_pdn_r;
    lgoe_mask_t soft_pdn_nxt;
    logic [31:0] prdata_r;
    logic [31:0] rd_mux;
    logic access;
    logic wr_en;
    logic rd_en;
    logic sel_low;
    logic sel_high;
    logic sel_pdn;
    logic sel_stat;
    logic mapped;
    logic lock_s1_r;
    logic lock_s2_r;
    lgoe_mask_t pdn_any;
    lgoe_mask_t stat_en;
    logic wr_low;
    logic wr_high;
    logic wr_pdn;

    // -------------------------------------------------------------------------
    // Decode helpers
    // -------------------------------------------------------------------------
    // One comparator shape serves both the write steering and the read mux.
    function automatic logic reg_hit(input logic [13:0] addr, input logic [13:0] base);
        reg_hit = (addr == base);
    endfunction

    assign access = psel_i & penable_i;
    assign sel_low = reg_hit(paddr_i, `LGOE_ADDR_GATE_LOW);
    assign sel_high = reg_hit(paddr_i, `LGOE_ADDR_GATE_HIGH);
    assign sel_pdn = reg_hit(paddr_i, `LGOE_ADDR_PDN_CTRL);
    assign sel_stat = reg_hit(paddr_i, `LGOE_ADDR_STATUS);
    assign mapped = sel_low | sel_high | sel_pdn | sel_stat;
    assign wr_en = access & pwrite_i & mapped & ~sel_stat & pstrb_i[0];
    assign wr_low = wr_en & sel_low;
    assign wr_high = wr_en & sel_high;
    assign wr_pdn = wr_en & sel_pdn;
    // Read data is captured at the end of the setup cycle so that it already
    // stands in the access cycle, at the edge where the master takes it.
    assign rd_en = psel_i & ~penable_i & ~pwrite_i;
    assign pready_o = 1'b1;
    assign pslverr_o = access & ~mapped;
    assign prdata_o = prdata_r;

    // Write steering; only the lane 0 strobe is checked, and the power-down write also takes bits 11:8 from lane 1.
    assign gate_nxt = wr_low ? {gate_r[11:8], pwdata_i[7:0]} :
        wr_high ? {pwdata_i[3:0], gate_r[7:0]} :
        gate_r;
    assign soft_pdn_nxt = wr_pdn ? pwdata_i[11:0] : soft_pdn_r;

    // Status rebuilds the enables from the synchronised lock level, so the read
    // path never captures the raw asynchronous input into a flop.
    assign stat_en = ~pdn_any & (~gate_r | {12{lock_s2_r}});
    assign rd_mux = sel_low ? {24'h000000, gate_r[7:0]} :
        sel_high ? {28'h0000000, gate_r[11:8]} :
        sel_pdn ? {20'h00000, soft_pdn_r} :
        sel_stat ? {15'h0000, lock_s2_r, 4'h0, stat_en} :
        32'h00000000;

    // -------------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------------
    // Reset clears every gate, so outputs ignore the lock until software opts in.
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gate_r <= `LGOE_GATE_RST;
        end else begin
            gate_r <= gate_nxt;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            soft_pdn_r <= `LGOE_PDN_RST;
        end else begin
            soft_pdn_r <= soft_pdn_nxt;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prdata_r <= 32'h00000000;
        end else begin
            prdata_r <= rd_en ? rd_mux : prdata_r;
        end
    end

    // The status copy of the lock level is synchronised; the gating path is not.
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lock_s1_r <= 1'b0;
            lock_s2_r <= 1'b0;
        end else begin
            lock_s1_r <= current_source_lock_indicator_i;
            lock_s2_r <= lock_s1_r;
        end
    end

    // -------------------------------------------------------------------------
    // Gating
    // -------------------------------------------------------------------------
    // The enable is combinational so an unlock removes the clock at once,
    // trading a possible runt edge for zero added latency.
    assign pdn_any = other_pdn_i | soft_pdn_r;

    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g = g + 1) begin : g_out
            assign out_enable_o[g] = ~pdn_any[g] &
                (~gate_r[g] | current_source_lock_indicator_i);
            a_lock_follow: assert property (
                @(posedge core_clk_i) disable iff (!rst_b_i)
                (gate_r[g] && !pdn_any[g]) |->
                (out_enable_o[g] == current_source_lock_indicator_i))
                else $error("Gated output does not follow the lock indicator.");
        end
    endgenerate

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    a_gate_low_off: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (gate_r[0] && !current_source_lock_indicator_i) |-> !out_enable_o[0])
        else $error("Gated output 0 on while unlocked.");
    a_gate_high_on: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (current_source_lock_indicator_i && !pdn_any[7]) |-> out_enable_o[7])
        else $error("Output 7 off while locked and not powered down.");
    a_pdn_wins: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (other_pdn_i != 12'h000) |-> ((out_enable_o & other_pdn_i) == 12'h000))
        else $error("Powered-down output is enabled.");
    a_soft_pdn: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (soft_pdn_r != 12'h000) |-> ((out_enable_o & soft_pdn_r) == 12'h000))
        else $error("Software powered-down output is enabled.");
    a_low_write: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (wr_en && sel_low) |=> (gate_r[7:0] == $past(pwdata_i[7:0])))
        else $error("Low gate register not written.");
    a_high_write: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (wr_en && sel_high) |=> (gate_r[11:8] == $past(pwdata_i[3:0])))
        else $error("High gate register not written.");
    a_rd_in_access: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (access && !pwrite_i && sel_low) |-> (prdata_o == {24'h000000, gate_r[7:0]}))
        else $error("Low gate read data not standing in the access cycle.");
    a_rd_high: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (access && !pwrite_i && sel_high) |-> (prdata_o == {28'h0000000, gate_r[11:8]}))
        else $error("High gate read data not standing in the access cycle.");
    a_ungated_free: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (!gate_r[11] && !pdn_any[11]) |-> out_enable_o[11])
        else $error("Ungated output 11 affected by lock.");
    a_no_delay: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (gate_r[8] && !pdn_any[8]) |-> (out_enable_o[8] == current_source_lock_indicator_i))
        else $error("Gated output 8 lags the lock indicator.");
    a_bad_addr: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (access && !mapped) |-> pslverr_o ##1 ($stable(gate_r) && $stable(soft_pdn_r)))
        else $error("Unmapped access not refused.");
    a_err_rdata: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (access && !pwrite_i && !mapped) |-> (prdata_o == 32'h00000000))
        else $error("Unmapped read returned data.");
    a_strobe_off: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (access && pwrite_i && !pstrb_i[0]) |=> $stable(gate_r))
        else $error("Write without lane 0 strobe changed a gate.");
    a_status_ro: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (access && pwrite_i && sel_stat) |=> ($stable(gate_r) && $stable(soft_pdn_r)))
        else $error("Status write changed a register.");
    a_gate_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        !(wr_low || wr_high) |=> $stable(gate_r))
        else $error("Gate register changed without a write.");
    a_pdn_write: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        wr_pdn |=> (soft_pdn_r == $past(pwdata_i[11:0])))
        else $error("Software power-down register not written.");
    a_pdn_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        !wr_pdn |=> $stable(soft_pdn_r))
        else $error("Software power-down changed without a write.");

    // -------------------------------------------------------------------------
    // Cover points
    // -------------------------------------------------------------------------
    c_lock_gate: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
        gate_r[0] && !out_enable_o[0]);
    c_relock: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
        gate_r[0] && !out_enable_o[0] ##1 out_enable_o[0]);
    c_pdn_locked: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
        current_source_lock_indicator_i && other_pdn_i[5] && gate_r[5]);
    c_soft_pdn: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
        current_source_lock_indicator_i && soft_pdn_r[0] && gate_r[0]);
    c_err_access: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
        access && pslverr_o);

endmodule // lgoe_gate

//--- common/lgoe_defines.svh
// Register offsets, field layout and reset values of the lock-gated output enable block.
`ifndef LGOE_DEFINES_SVH
`define LGOE_DEFINES_SVH

// -----------------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------------
`define LGOE_IDX_GATE_LOW 12'h0FC
`define LGOE_IDX_GATE_HIGH 12'h0FD
`define LGOE_IDX_PDN_CTRL 12'h0FE
`define LGOE_IDX_STATUS 12'h0FF
`define LGOE_ADDR_GATE_LOW 14'h03F0
`define LGOE_ADDR_GATE_HIGH 14'h03F4
`define LGOE_ADDR_PDN_CTRL 14'h03F8
`define LGOE_ADDR_STATUS 14'h03FC

// -----------------------------------------------------------------------------
// Fields and reset values
// -----------------------------------------------------------------------------
`define LGOE_GATE_LOW_W 8
`define LGOE_GATE_HIGH_W 4
`define LGOE_NUM_OUT 12
`define LGOE_GATE_RST 12'h000
`define LGOE_PDN_RST 12'h000

`endif

//--- common/lgoe_pkg.sv
// Types shared by the lock-gated output enable block.
package lgoe_pkg;
    typedef logic [11:0] lgoe_mask_t;
endpackage

//--- testbench/lgoe_gate_test.sv
// Self-checking testbench of the lock-gated output enable block.
`timescale 1ns/100ps
`include "lgoe_defines.svh"
module lgoe_gate_test
    import lgoe_pkg::*;
;
    logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, lock = 0, pready, pslverr;
    logic [13:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    lgoe_mask_t other_pdn = 0, out_en;
    int num_errors = 0, tests_run = 0;
    lgoe_gate dut_u (.core_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .current_source_lock_indicator_i(lock), .other_pdn_i(other_pdn), .out_enable_o(out_en));
    // -------------------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Read data stands in the access cycle and is taken at the edge where pready is high.
    task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d,
        input logic err_exp);
        @(posedge clk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        check("pslverr", pslverr, err_exp);
        psel <= 0;
        penable <= 0;
    endtask
    // The lock level changes before an edge and is judged 1 ns after it, when lock_s1_r has already sampled it.
    task automatic gate(input logic l, input lgoe_mask_t opdn, input lgoe_mask_t exp);
        lock <= l;
        other_pdn <= opdn;
        @(posedge clk);
        #1 check("out_enable", out_en, exp);
    endtask
    // -------------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------------
    task automatic t_reset();
        apb(0, `LGOE_ADDR_GATE_LOW, 0, 0);
        check("gate_low_rst", rd, 32'h0);
        apb(0, `LGOE_ADDR_GATE_HIGH, 0, 0);
        check("gate_high_rst", rd, 32'h0);
        gate(0, 12'h000, 12'hFFF);
        $display("test reset done");
    endtask
    task automatic t_gate();
        apb(1, `LGOE_ADDR_GATE_LOW, 32'h000000A5, 0);
        apb(1, `LGOE_ADDR_GATE_HIGH, 32'h00000009, 0);
        apb(0, `LGOE_ADDR_GATE_LOW, 0, 0);
        check("gate_low_rd", rd, 32'h000000A5);
        apb(0, `LGOE_ADDR_GATE_HIGH, 0, 0);
        check("gate_high_rd", rd, 32'h00000009);
        gate(0, 12'h000, 12'h65A);
        gate(1, 12'h000, 12'hFFF);
        gate(0, 12'h000, 12'h65A);
        $display("test gate done");
    endtask
    task automatic t_other();
        gate(1, 12'h0F0, 12'hF0F);
        apb(1, `LGOE_ADDR_PDN_CTRL, 32'h0000000F, 0);
        gate(1, 12'h0F0, 12'hF00);
        gate(0, 12'h0F0, 12'h600);
        apb(1, `LGOE_ADDR_PDN_CTRL, 32'h0, 0);
        $display("test other power-down done");
    endtask
    task automatic t_err();
        apb(0, 14'h0100, 0, 1);
        check("unmapped_rd", rd, 32'h0);
        apb(1, 14'h0104, 32'hFF, 1);
        apb(1, `LGOE_ADDR_STATUS, 32'hFFF, 0);
        pstrb <= 4'hE;
        apb(1, `LGOE_ADDR_GATE_LOW, 32'h000000FF, 0);
        pstrb <= 4'hF;
        apb(0, `LGOE_ADDR_GATE_LOW, 0, 0);
        check("gate_low_kept", rd, 32'h000000A5);
        gate(1, 12'h000, 12'hFFF);
        apb(0, `LGOE_ADDR_STATUS, 0, 0);
        check("status_rd", rd, 32'h00010FFF);
        $display("test refused access done");
    endtask
    task automatic t_midreset();
        lock <= 0;
        rst_b <= 0;
        repeat (2) @(posedge clk);
        rst_b <= 1;
        apb(0, `LGOE_ADDR_GATE_LOW, 0, 0);
        check("gate_low_rst2", rd, 32'h0);
        gate(0, 12'h000, 12'hFFF);
        $display("test mid-run reset done");
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // -------------------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // -------------------------------------------------------------------------
    initial begin
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1;
        t_reset();
        t_gate();
        t_other();
        t_err();
        t_midreset();
        stop_test();
    end
    initial begin
        #200000;
        num_errors++;
        stop_test();
    end
endmodule // lgoe_gate_test
